/* rtl/tslr_regs.v */
// Purpose: High threshold and die identification registers of a two-wire sensor
// Assumes: Serial engine on mclk delivers pointer, byte strobes and transfer end
// Notes: High threshold is two's complement, same layout as the result
// Behaviour
// - A 12-bit writable high threshold sits in bits 15:4, bits 3:0 read zero.
// - Reset loads the high threshold with 5000h.
// - The threshold is compared as a signed value with the result layout.
// - Pointer 0Fh selects the die identification register.
// - The identification register is a fixed read-only 16-bit value.
// - The identification register exists only on the full-address variant.
// - The identification high byte returns a fixed naming code.
// - Two-byte registers accept one-byte or two-byte reads; the high threshold also accepts one-byte or two-byte writes.
// - A one-byte write updates bits 15:8 and a one-byte read returns bits 15:8.
// - The decoder supports 32 addresses full, 4 reduced.
`timescale 1ns/1ps
`include "tslr_defs.vh"
module tslr_regs #(
   parameter FULL = 1
) (
   input wire mclk,
   input wire nrst,
   input wire [4:0] addr_strap,
   input wire [6:0] bus_addr,
   output wire addr_hit,
   input wire [7:0] pointer,
   input wire wr_stb,
   input wire [7:0] wr_byte,
   input wire rd_stb,
   input wire xfer_end,
   output reg [7:0] rd_byte,
   output wire [15:0] high_thresh,
   input wire [15:0] temp_result,
   output reg over_high
);
   // Pointer classes after decode
   localparam KIND_NONE = 2'b00;
   localparam KIND_HIGH = 2'b01;
   localparam KIND_ID = 2'b10;
   // Write byte position
   localparam WR_MSB = 1'b0;
   localparam WR_LSB = 1'b1;
   // Read byte position
   localparam RD_MSB = 1'b0;
   localparam RD_LSB = 1'b1;
   localparam SEL_W = 5;

   reg [SEL_W-1:0] strap_s1_q;
   reg [SEL_W-1:0] strap_s2_q;
   reg [15:0] high_q;
   reg [15:0] high_d;
   reg wr_state_q;
   reg wr_state_d;
   reg rd_state_q;
   reg rd_state_d;
   reg [7:0] rd_byte_d;
   reg over_d;
   wire [SEL_W-1:0] sel;
   wire [1:0] cur_kind;
   wire [15:0] cur_word;

   // Class of a pointer; identification hidden on the reduced variant
   function [1:0] ptr_kind;
      input [7:0] ptr;
      input full;
      begin
         if (ptr == `TSLR_PTR_HIGH) begin
            ptr_kind = KIND_HIGH;
         end else if ((ptr == `TSLR_PTR_ID) && full) begin
            ptr_kind = KIND_ID;
         end else begin
            ptr_kind = KIND_NONE;
         end
      end
   endfunction

   // Word shown for a pointer class
   function [15:0] reg_word;
      input [1:0] kind;
      input [15:0] high;
      begin
         case (kind)
            KIND_HIGH: begin
               reg_word = {high[15:4], 4'h0};
            end
            KIND_ID: begin
               reg_word = {`TSLR_ID_NAME, `TSLR_ID_LOW};
            end
            default: begin
               reg_word = 16'h0000;
            end
         endcase
      end
   endfunction

   // Byte of a word in transfer order, upper first
   function [7:0] pick_byte;
      input [15:0] word;
      input lower;
      begin
         if (lower) begin
            pick_byte = word[7:0];
         end else begin
            pick_byte = word[15:8];
         end
      end
   endfunction

   // Strap code honoured by the variant
   function [SEL_W-1:0] strap_sel;
      input [SEL_W-1:0] strap;
      input full;
      begin
         if (full) begin
            strap_sel = strap;
         end else begin
            strap_sel = {{(SEL_W-2){1'b0}}, strap[1:0]};
         end
      end
   endfunction

   // Signed compare of two 12-bit fields
   function at_or_above;
      input [11:0] value;
      input [11:0] limit;
      begin
         at_or_above = ($signed(value) >= $signed(limit));
      end
   endfunction

   // Straps come from pins
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strap_s1_q <= 5'h00;
         strap_s2_q <= 5'h00;
      end else begin
         strap_s1_q <= addr_strap;
         strap_s2_q <= strap_s1_q;
      end
   end

   assign sel = strap_sel(strap_s2_q, FULL != 0);

   tslr_addr_match #(.SEL_W(SEL_W)) u_match (
      .sel(sel),
      .bus_addr(bus_addr),
      .match(addr_hit)
   );

   assign cur_kind = ptr_kind(pointer, FULL != 0);
   assign cur_word = reg_word(cur_kind, high_q);

   // First byte updates 15:8 at once; later bytes fill 7:4
   always @* begin
      high_d = high_q;
      wr_state_d = wr_state_q;
      if (xfer_end) begin
         wr_state_d = WR_MSB;
      end else if (wr_stb) begin
         case (wr_state_q)
            WR_MSB: begin
               if (cur_kind == KIND_HIGH) begin
                  high_d[15:8] = wr_byte;
               end
               wr_state_d = WR_LSB;
            end
            WR_LSB: begin
               if (cur_kind == KIND_HIGH) begin
                  high_d[7:4] = wr_byte[7:4];
               end
               wr_state_d = WR_LSB;
            end
            default: begin
               wr_state_d = WR_MSB;
            end
         endcase
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         high_q <= `TSLR_HIGH_RST;
         wr_state_q <= WR_MSB;
      end else begin
         high_q <= high_d;
         wr_state_q <= wr_state_d;
      end
   end

   // Idle shows the upper byte so a one-byte read needs no strobe
   always @* begin
      rd_byte_d = rd_byte;
      rd_state_d = rd_state_q;
      if (xfer_end) begin
         rd_state_d = RD_MSB;
         rd_byte_d = pick_byte(cur_word, 1'b0);
      end else if (rd_stb) begin
         case (rd_state_q)
            RD_MSB: begin
               rd_state_d = RD_LSB;
               rd_byte_d = pick_byte(cur_word, 1'b1);
            end
            RD_LSB: begin
               rd_state_d = RD_MSB;
               rd_byte_d = pick_byte(cur_word, 1'b0);
            end
            default: begin
               rd_state_d = RD_MSB;
               rd_byte_d = pick_byte(cur_word, 1'b0);
            end
         endcase
      end else if (rd_state_q == RD_MSB) begin
         rd_byte_d = pick_byte(cur_word, 1'b0);
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_state_q <= RD_MSB;
         rd_byte <= 8'h00;
      end else begin
         rd_state_q <= rd_state_d;
         rd_byte <= rd_byte_d;
      end
   end

   assign high_thresh = reg_word(KIND_HIGH, high_q);

   always @* begin
      over_d = at_or_above(temp_result[15:4], high_q[15:4]);
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         over_high <= 1'b0;
      end else begin
         over_high <= over_d;
      end
   end
endmodule

/* rtl/tslr_defs.vh */
// Purpose: Constants for the limit and identification register bank
// Assumes: 8-bit pointer, 16-bit registers
// Notes: Identifier value is arbitrary
`ifndef TSLR_DEFS_VH
`define TSLR_DEFS_VH
`define TSLR_PTR_HIGH 8'h03
`define TSLR_PTR_ID 8'h0F
`define TSLR_HIGH_RST 16'h5000
`define TSLR_HIGH_MSB 15
`define TSLR_HIGH_LSB 4
// Naming code value is arbitrary
`define TSLR_ID_NAME 8'hA5
`define TSLR_ID_LOW 8'h00
`define TSLR_ADDR_FULL 32
`define TSLR_ADDR_RED 4
`define TSLR_BASE_ADDR 7'h40
`endif

/* rtl/tslr_addr_match.v */
// Purpose: Bus address match against strap-selected address
// Assumes: Straps already synchronised
// Notes: Capacity sets how many strap codes are honoured
`timescale 1ns/1ps
`include "tslr_defs.vh"
module tslr_addr_match #(
   parameter SEL_W = 5
) (
   input wire [SEL_W-1:0] sel,
   input wire [6:0] bus_addr,
   output wire match
);
   wire [6:0] mine;
   assign mine = `TSLR_BASE_ADDR + {{(7-SEL_W){1'b0}}, sel};
   assign match = (bus_addr == mine);
endmodule

/* bench/tslr_regs_asserts.sv */
// Purpose: port checks; Assumes: FULL=1; Notes: id high byte A5
`timescale 1ns/1ps
module tslr_chk(input wire mclk,nrst,input wire [4:0] addr_strap,input wire [6:0] bus_addr,
input wire addr_hit,rd_stb,wr_stb,xfer_end,over_high,input wire [7:0] pointer,rd_byte,
input wire [15:0] high_thresh,temp_result);
default clocking @(posedge mclk);endclocking
default disable iff(!nrst);
a_lo_zero:assert property(high_thresh[3:0]==4'h0)else $error("lsb");
a_rst_load:assert property(!$past(nrst)|->high_thresh==16'h5000)else $error("rst");
a_sign_cmp:assert property(1|=>over_high==(($signed($past(temp_result))>>>4)>=
($signed($past(high_thresh))>>>4)))else $error("cmp");
a_id_msb:assert property(xfer_end&&pointer==8'h0F|->##2 rd_byte==8'hA5)else $error("id");
a_id_lsb:assert property(rd_stb&&pointer==8'h0F&&rd_byte==8'hA5|->##2 rd_byte==8'h00)
else $error("il");
a_wr_other:assert property(wr_stb&&pointer!=8'h03|=>$stable(high_thresh))else $error("ro");
a_hi_rd:assert property(xfer_end&&pointer==8'h03|->##2 rd_byte==high_thresh[15:8])
else $error("rd");
a_addr_hit:assert property(addr_strap==5'h1F[*3]|->addr_hit==(bus_addr==7'h5F))
else $error("ad");
endmodule
bind tslr_regs tslr_chk chk(.*);

/* bench/tslr_host.sv */
// Purpose: host model; Assumes: one strobe per two cycles; Notes: idle data inverted
`timescale 1ns/1ps
module tslr_host(input wire mclk,output reg [7:0] pointer=8'h03,wr_byte=8'h00,
output reg wr_stb=1'h0,rd_stb=1'h0,xfer_end=1'h0);
task op(input [2:0] k,input [7:0] b);begin
{wr_stb,rd_stb,xfer_end}=k;wr_byte=b;@(posedge mclk);#1;
{wr_stb,rd_stb,xfer_end}=3'h0;wr_byte=~b;@(posedge mclk);#1;end
endtask
endmodule

/* bench/tslr_regs_tb.sv */
// Purpose: bench; Assumes: FULL=1; Notes: host model strobes
`timescale 1ns/1ps
module tslr_regs_tb;
reg mclk=0,nrst=0;
reg [4:0] addr_strap=5'h00;
reg [6:0] bus_addr=7'h00;
reg [15:0] temp_result=16'h0000;
wire addr_hit,over_high,wr_stb,rd_stb,xfer_end;
wire [7:0] pointer,wr_byte,rd_byte;
wire [15:0] high_thresh;
integer error_cnt=0,tests_run=0,cyc=0;
tslr_regs dut(.*);
tslr_host h(.*);
initial forever #5 mclk=~mclk;
always @(posedge mclk) if(++cyc>500) begin error_cnt++;test_done;end
task chk(input [15:0] n,s,e);begin tests_run++;
if(s!==e) begin error_cnt++;$display("[ERR] %s exp %h seen %h",n,e,s);end end
endtask
task test_done;begin $display("tests %0d errors %0d",tests_run,error_cnt);
if(error_cnt==0&&tests_run>0) $display("NO MISMATCHES");
else $display("MISMATCHES SEEN");
$finish;end
endtask
task t_wr;begin h.op(3'h4,8'hAA);h.op(3'h4,8'hB7);h.op(3'h1,8'h00);
chk("w2",high_thresh,16'hAAB0);
h.op(3'h4,8'h12);h.op(3'h1,8'h00);chk("w1",high_thresh,16'h12B0);
chk("rm",rd_byte,16'h0012);
h.op(3'h2,8'h00);chk("rl",rd_byte,16'h00B0);end
endtask
task t_id;begin h.pointer=8'h0F;h.op(3'h4,8'h33);h.op(3'h1,8'h00);
chk("ro",high_thresh,16'h12B0);
chk("im",rd_byte,16'h00A5);
h.op(3'h2,8'h00);chk("il",rd_byte,16'h0000);end
endtask
task t_cmp;begin temp_result=16'h12B0;h.op(3'h0,8'h00);chk("ge",over_high,16'h0001);
temp_result=16'hF000;h.op(3'h0,8'h00);chk("ng",over_high,16'h0000);end
endtask
task t_ad;begin addr_strap=5'h1F;bus_addr=7'h5F;h.op(3'h0,8'h00);
chk("ad",addr_hit,16'h0001);
bus_addr=7'h5E;#1 chk("an",addr_hit,16'h0000);end
endtask
initial begin repeat(6) @(posedge mclk);#1 nrst=1;chk("rs",high_thresh,16'h5000);
t_wr;t_id;t_cmp;t_ad;test_done;end
endmodule
